// ---- dv/testbench.sv ----
`include "wdt_params.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk_in = 0, arst_n_in = 0, osc_nonstop_opt_in = 0, cpu_wr_in = 0;
  logic cpu_rd_in = 0, cpu_bitop_in = 0, internal_osc_tick_in = 0, xtal_tick_in = 0;
  logic xtal_running_in = 1, xtal_stabilising_in = 0, halt_in = 0, stop_in = 0;
  logic cpu_on_xtal_in = 0, internal_osc_stopped_in = 0, reset_cause_clear_in = 0;
  logic [15:0] cpu_addr_in = '0;
  logic [7:0] cpu_wdata_in = '0, cpu_rdata_out, reset_cause_out;
  logic cpu_wait_out, internal_reset_out, wdt_active_out, mode_locked_out;
  int fail_count = 0, n_checks = 0;

  // Short bases keep every overflow under a few thousand cycles
  program_loop_watchdog #(.OSC_BASE_LOG2(2), .XTAL_BASE_LOG2(3)) dut_u (.*);

  always #5 ref_clk_in = ~ref_clk_in;

  task automatic summarize;
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic b);
    @(negedge ref_clk_in);
    cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_wr_in = w;
    cpu_rd_in = !w;
    cpu_bitop_in = b;
    @(negedge ref_clk_in);
    cpu_wr_in = 0;
    cpu_rd_in = 0;
    cpu_bitop_in = 0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 0, 0);
    chk(cpu_rdata_out, exp);
  endtask

  task automatic wm(input logic [7:0] d);
    acc(`WDT_MODE_ADDR, d, 1, 0);
    chk(cpu_wait_out, 1);
    chk(mode_locked_out, 1);
  endtask

  task automatic boot(input logic ns);
    arst_n_in = 0;
    osc_nonstop_opt_in = ns;
    repeat (2) @(negedge ref_clk_in);
    arst_n_in = 1;
    @(negedge ref_clk_in);
  endtask

  task automatic fire(input int n);
    int i;
    for (i = 0; i < n + 4 && internal_reset_out !== 1'b1; i++) @(negedge ref_clk_in);
    chk(8'(i >= n - 2 && i < n + 4), 1);
    chk(reset_cause_out, 8'h10);
    repeat (10) @(negedge ref_clk_in);
    rd(`WDT_MODE_ADDR, 8'h67);
    reset_cause_clear_in = 1;
    @(negedge ref_clk_in);
    reset_cause_clear_in = 0;
  endtask

  task automatic mis(input logic [15:0] a, input logic [7:0] d, input logic b, input logic e);
    acc(a, d, 1, b);
    @(negedge ref_clk_in);
    chk(internal_reset_out, e);
    if (e) fire(0);
  endtask

  task automatic gated(input logic [7:0] m, input int n, input int hi);
    int g = $urandom_range(0, hi);
    {xtal_stabilising_in, stop_in, halt_in} = 3'(1 << g);
    xtal_running_in = g != 3;
    wm(m);
    repeat (60) @(negedge ref_clk_in);
    chk(internal_reset_out, 0);
    {xtal_stabilising_in, stop_in, halt_in} = 3'b000;
    xtal_running_in = 1;
    fire(n);
  endtask

  initial begin
    void'($urandom(32'h4070));
    boot(1);
    chk(reset_cause_out, 8'h00);
    rd(`WDT_MODE_ADDR, 8'h67);
    rd(`WDT_RESTART_ADDR, 8'h9a);
    chk(wdt_active_out, 1);
    internal_osc_tick_in = 1;
    repeat (6) begin
      repeat ($urandom_range(100, 400)) @(negedge ref_clk_in);
      acc(`WDT_RESTART_ADDR, 8'hac, 1, 0);
      chk(internal_reset_out, 0);
    end
    fire(512);
    for (int s = 0; s < 2; s++) begin
      boot(s[0]);
      internal_osc_tick_in = s[0];
      xtal_tick_in = !s[0];
      for (int k = 0; k < 8; k++) begin
        wm({5'b0110_1, 3'(k)});
        fire(s ? 4 << k : 8 << k);
      end
      wm(8'h68 | 8'($urandom_range(0, 7)));
      rd(`WDT_MODE_ADDR, {4'h6, !s[0], cpu_wdata_in[2:0]});
    end
    // A short random interval above may still be about to overflow
    boot(1);
    internal_osc_tick_in = 1;
    xtal_tick_in = 0;
    acc(`WDT_MODE_ADDR, 8'h60, 1, 1);
    rd(`WDT_MODE_ADDR, 8'h67);
    mis(`WDT_RESTART_ADDR, 8'($urandom_range(0, 171)), 0, 1);
    mis(`WDT_RESTART_ADDR, 8'hac, 1, 1);
    wm(8'h67);
    mis(`WDT_MODE_ADDR, 8'h67, 0, 1);
    boot(0);
    wm(8'h77 | 8'($urandom_range(0, 1) << 3));
    mis(`WDT_MODE_ADDR, 8'h67, 0, 0);
    mis(`WDT_RESTART_ADDR, 8'h12, 0, 0);
    mis(`WDT_RESTART_ADDR, 8'hac, 1, 0);
    repeat (600) @(negedge ref_clk_in);
    chk(internal_reset_out, 0);
    chk(wdt_active_out, 0);
    boot(0);
    gated(8'h60, 4, 1);
    boot(0);
    xtal_tick_in = 1;
    gated(8'h68, 8, 3);
    summarize;
  end

  initial begin
    #400_000;
    fail_count++;
    summarize;
  end
endmodule

`default_nettype wire

// ---- dv/wdt_props.sv ----
`include "wdt_params.svh"
`default_nettype none

module wdt_props (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Register access
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic cpu_bitop_in,
  input wire logic [7:0] cpu_wdata_in,
  input wire logic [7:0] cpu_rdata_out,
  input wire logic cpu_wait_out,
  // Reset and status
  input wire logic [7:0] reset_cause_out,
  input wire logic internal_reset_out,
  input wire logic wdt_active_out,
  input wire logic mode_locked_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Writes during a reset pulse are ignored, so both are gated by it
  wire logic mode_wr = cpu_wr_in && cpu_addr_in == `WDT_MODE_ADDR && !internal_reset_out;
  wire logic rs_wr = cpu_wr_in && cpu_addr_in == `WDT_RESTART_ADDR && !internal_reset_out;

  property p_pulse;
    $rose(internal_reset_out) |-> internal_reset_out[*8] ##1 !internal_reset_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
  property p_cause;
    $rose(internal_reset_out) |-> reset_cause_out[`WDT_CAUSE_BIT];
  endproperty
  a_cause: assert property (p_cause) else $error("cause bit not set");
  property p_wait;
    mode_wr |=> cpu_wait_out;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait after mode write");
  property p_rd;
    cpu_rd_in && cpu_addr_in == `WDT_RESTART_ADDR && !internal_reset_out
      |=> cpu_rdata_out == `WDT_RESTART_READ;
  endproperty
  a_rd: assert property (p_rd) else $error("restart read value wrong");
  property p_bad;
    rs_wr && wdt_active_out && !cpu_bitop_in && cpu_wdata_in != `WDT_RESTART_CODE
      |=> internal_reset_out;
  endproperty
  a_bad: assert property (p_bad) else $error("bad restart value ignored");
  property p_bit;
    rs_wr && wdt_active_out && cpu_bitop_in |=> internal_reset_out;
  endproperty
  a_bit: assert property (p_bit) else $error("bit access to restart ignored");
  property p_twice;
    mode_wr && !cpu_bitop_in && mode_locked_out && wdt_active_out |=> internal_reset_out;
  endproperty
  a_twice: assert property (p_twice) else $error("second mode write ignored");
  property p_lock;
    mode_wr && !cpu_bitop_in && !mode_locked_out |=> mode_locked_out;
  endproperty
  a_lock: assert property (p_lock) else $error("mode not locked");
  property p_quiet;
    rs_wr && mode_locked_out && !wdt_active_out |=> !internal_reset_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stopped watchdog reset");

  c_fire: cover property ($rose(internal_reset_out));
  c_wait: cover property (cpu_wait_out);
  c_quiet: cover property (rs_wr && !wdt_active_out);
endmodule

bind program_loop_watchdog wdt_props props_u (.*);

`default_nettype wire

// ---- inc/wdt_params.svh ----
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_MODE_ADDR 16'hff98
`define WDT_RESTART_ADDR 16'hff99
`define WDT_MODE_RST 8'h67
`define WDT_RESTART_CODE 8'hac
`define WDT_RESTART_READ 8'h9a
`define WDT_FIXED_BITS 3'h3
`define WDT_FIXED_MSB 7
`define WDT_FIXED_LSB 5
`define WDT_CS_MSB 4
`define WDT_CS_LSB 3
`define WDT_OVF_MSB 2
`define WDT_OVF_LSB 0
`define WDT_CAUSE_BIT 4
`define WDT_OSC_BASE_LOG2 11
`define WDT_XTAL_BASE_LOG2 13
`define WDT_CNT_W 21
`define WDT_CLK_NS 10
`define WDT_RST_PULSE_NS 80
`define WDT_RST_PULSE_CYC ((`WDT_RST_PULSE_NS + `WDT_CLK_NS - 1) / `WDT_CLK_NS)
`define WDT_PULSE_W 4

`endif

// ---- inc/wdt_pkg.sv ----
`default_nettype none

package wdt_pkg;

  typedef enum logic [1:0] {
    CLK_INT_OSC = 2'b00,
    CLK_XTAL = 2'b01,
    CLK_STOP_A = 2'b10,
    CLK_STOP_B = 2'b11
  } clk_sel_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_FIRE = 1'b1
  } wdt_state_t;

endpackage

`default_nettype wire

// ---- src/program_loop_watchdog.sv ----
`include "wdt_params.svh"
`default_nettype none

module program_loop_watchdog
  import wdt_pkg::*;
#(
  parameter int OSC_BASE_LOG2 = `WDT_OSC_BASE_LOG2,
  parameter int XTAL_BASE_LOG2 = `WDT_XTAL_BASE_LOG2
) (
  // Clock and chip reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Factory mask option strap, high for non-stoppable oscillator
  input wire logic osc_nonstop_opt_in,
  // CPU data-memory access
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic cpu_bitop_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic [7:0] cpu_rdata_out,
  output logic cpu_wait_out,
  // Counting sources
  input wire logic internal_osc_tick_in,
  input wire logic xtal_tick_in,
  // Clock and standby status
  input wire logic xtal_running_in,
  input wire logic xtal_stabilising_in,
  input wire logic halt_in,
  input wire logic stop_in,
  input wire logic cpu_on_xtal_in,
  input wire logic internal_osc_stopped_in,
  // Reset cause and internal reset
  input wire logic reset_cause_clear_in,
  output logic [7:0] reset_cause_out,
  output logic internal_reset_out,
  // Status
  output logic wdt_active_out,
  output logic mode_locked_out
);

  localparam logic [`WDT_CNT_W-1:0] CNT_ONE = `WDT_CNT_W'(1);
  localparam logic [`WDT_PULSE_W-1:0] PULSE_LAST =
    `WDT_PULSE_W'(`WDT_RST_PULSE_CYC - 1);
  localparam logic [4:0] OSC_BASE = 5'(OSC_BASE_LOG2);
  localparam logic [4:0] XTAL_BASE = 5'(XTAL_BASE_LOG2);

  // Strap capture
  logic strap_taken_q;
  logic nonstop_q;

  // Mode register fields
  clk_sel_t clk_sel_q;
  clk_sel_t clk_sel_d;
  logic [2:0] ovf_sel_q;
  logic [2:0] ovf_sel_d;
  logic mode_locked_q;
  logic mode_locked_d;

  // Counter
  logic [`WDT_CNT_W-1:0] count_q;
  logic [`WDT_CNT_W-1:0] count_d;
  logic count_en;

  // Reset sequencer
  wdt_state_t state_q;
  wdt_state_t state_d;
  logic [`WDT_PULSE_W-1:0] pulse_q;
  logic [`WDT_PULSE_W-1:0] pulse_d;

  // Output registers
  logic [7:0] rdata_q;
  logic wait_q;
  logic [7:0] cause_q;
  logic [7:0] cause_d;
  logic int_rst_q;
  logic active_q;

  // The strap is sampled on the first edge after release, never under reset.
  // Until then the safer non-stoppable reading applies.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nonstop_q <= 1'b1;
    end else if (!strap_taken_q) begin
      nonstop_q <= osc_nonstop_opt_in;
    end
  end

  // Address decode
  wire mode_hit = cpu_addr_in == `WDT_MODE_ADDR;
  wire restart_hit = cpu_addr_in == `WDT_RESTART_ADDR;
  wire firing = state_q == ST_FIRE;
  wire bus_wr = cpu_wr_in & ~firing;

  // Single-bit writes to the mode register change no field but still stall the CPU
  wire mode_wr_any = bus_wr & mode_hit;
  wire mode_wr = mode_wr_any & ~cpu_bitop_in;
  wire mode_accept = mode_wr & ~mode_locked_q;
  wire mode_second = mode_wr & mode_locked_q;

  wire restart_wr = bus_wr & restart_hit;
  wire restart_code_ok = cpu_wdata_in == `WDT_RESTART_CODE;
  wire restart_ok = restart_wr & ~cpu_bitop_in & restart_code_ok;
  wire restart_bad_val = restart_wr & ~cpu_bitop_in & ~restart_code_ok;
  wire restart_bitop = restart_wr & cpu_bitop_in;

  // Stopped only by code 1x, which the non-stoppable option can never hold
  wire wdt_stopped = clk_sel_q[1] & ~nonstop_q;
  wire misuse = mode_second | restart_bad_val | restart_bitop;
  wire misuse_reset = misuse & ~wdt_stopped;

  // Written clock select, forced to the oscillator under the option
  wire [1:0] wr_cs = cpu_wdata_in[`WDT_CS_MSB:`WDT_CS_LSB];
  wire [1:0] new_cs = nonstop_q ? CLK_INT_OSC : wr_cs;
  wire [2:0] wr_ovf = cpu_wdata_in[`WDT_OVF_MSB:`WDT_OVF_LSB];

  // Overflow threshold from the selected source and interval
  wire sel_xtal = clk_sel_q == CLK_XTAL;
  wire [4:0] base_log2 = sel_xtal ? XTAL_BASE : OSC_BASE;
  wire [4:0] lim_log2 = base_log2 + {2'b00, ovf_sel_q};
  wire [`WDT_CNT_W-1:0] lim_m1 = (CNT_ONE << lim_log2) - CNT_ONE;
  wire overflow = count_en & (count_q == lim_m1) & ~firing;

  wire trigger = (overflow | misuse_reset) & ~firing;

  // Read mux: fixed upper bits always read 011
  wire [7:0] mode_byte = {`WDT_FIXED_BITS, clk_sel_q, ovf_sel_q};
  wire [7:0] read_mux = mode_hit ? mode_byte :
                        restart_hit ? `WDT_RESTART_READ :
                        8'h00;

  wdt_tick_gate u_tick_gate (
    .clk_sel_in(clk_sel_q),
    .nonstop_opt_in(nonstop_q),
    .internal_osc_tick_in(internal_osc_tick_in),
    .xtal_tick_in(xtal_tick_in),
    .xtal_running_in(xtal_running_in),
    .xtal_stabilising_in(xtal_stabilising_in),
    .halt_in(halt_in),
    .stop_in(stop_in),
    .cpu_on_xtal_in(cpu_on_xtal_in),
    .internal_osc_stopped_in(internal_osc_stopped_in),
    .count_en_out(count_en)
  );

  // Mode register next value; a watchdog reset restores the reset image
  always_comb begin
    clk_sel_d = clk_sel_q;
    ovf_sel_d = ovf_sel_q;
    mode_locked_d = mode_locked_q;
    if (firing) begin
      clk_sel_d = clk_sel_t'(2'(`WDT_MODE_RST >> `WDT_CS_LSB));
      ovf_sel_d = 3'(`WDT_MODE_RST);
      mode_locked_d = 1'b0;
    end else if (mode_accept) begin
      clk_sel_d = clk_sel_t'(new_cs);
      ovf_sel_d = wr_ovf;
      mode_locked_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_sel_q <= clk_sel_t'(2'(`WDT_MODE_RST >> `WDT_CS_LSB));
      ovf_sel_q <= 3'(`WDT_MODE_RST);
    end else begin
      clk_sel_q <= clk_sel_d;
      ovf_sel_q <= ovf_sel_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_locked_q <= 1'b0;
    end else begin
      mode_locked_q <= mode_locked_d;
    end
  end

  // Counter: held, not cleared, while the clock is withheld
  always_comb begin
    count_d = count_q;
    if (firing || trigger) begin
      count_d = '0;
    end else if (mode_accept) begin
      count_d = '0;
    end else if (restart_ok) begin
      count_d = '0;
    end else if (count_en) begin
      count_d = count_q + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Reset sequencer: a fixed pulse so that every sink sees it
  always_comb begin
    state_d = state_q;
    pulse_d = pulse_q;
    unique case (state_q)
      ST_RUN: begin
        if (trigger) begin
          state_d = ST_FIRE;
          pulse_d = PULSE_LAST;
        end
      end
      ST_FIRE: begin
        if (pulse_q == '0) begin
          state_d = ST_RUN;
        end else begin
          pulse_d = pulse_q - `WDT_PULSE_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_RUN;
      pulse_q <= '0;
    end else begin
      state_q <= state_d;
      pulse_q <= pulse_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      int_rst_q <= 1'b0;
    end else begin
      int_rst_q <= state_d == ST_FIRE;
    end
  end

  // Cause flag: a new watchdog reset wins over a clear in the same cycle
  always_comb begin
    cause_d = cause_q;
    if (reset_cause_clear_in) begin
      cause_d[`WDT_CAUSE_BIT] = 1'b0;
    end
    if (trigger) begin
      cause_d[`WDT_CAUSE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cause_q <= 8'h00;
    end else begin
      cause_q <= cause_d;
    end
  end

  // Read data is registered; idle and unmapped reads return zero
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 8'h00;
    end else if (cpu_rd_in) begin
      rdata_q <= read_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Any mode write outside a reset pulse stalls the CPU for one cycle
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= mode_wr_any;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_q <= 1'b0;
    end else begin
      active_q <= ~wdt_stopped & ~firing;
    end
  end

  assign cpu_rdata_out = rdata_q;
  assign cpu_wait_out = wait_q;
  assign reset_cause_out = cause_q;
  assign internal_reset_out = int_rst_q;
  assign wdt_active_out = active_q;
  assign mode_locked_out = mode_locked_q;

endmodule

`default_nettype wire

// ---- src/wdt_tick_gate.sv ----
`include "wdt_params.svh"
`default_nettype none

module wdt_tick_gate
  import wdt_pkg::*;
(
  // Configuration
  input wire clk_sel_t clk_sel_in,
  input wire logic nonstop_opt_in,
  // Source ticks
  input wire logic internal_osc_tick_in,
  input wire logic xtal_tick_in,
  // Clock and standby status
  input wire logic xtal_running_in,
  input wire logic xtal_stabilising_in,
  input wire logic halt_in,
  input wire logic stop_in,
  input wire logic cpu_on_xtal_in,
  input wire logic internal_osc_stopped_in,
  // Gated count enable
  output logic count_en_out
);

  wire standby = halt_in | stop_in;
  wire osc_withheld = standby | (cpu_on_xtal_in & internal_osc_stopped_in);
  wire xtal_ok = xtal_running_in & ~standby & ~xtal_stabilising_in;
  wire osc_free_en = internal_osc_tick_in;
  wire osc_gated_en = internal_osc_tick_in & ~osc_withheld;
  wire xtal_en = xtal_tick_in & xtal_ok;

  always_comb begin
    count_en_out = 1'b0;
    if (nonstop_opt_in) begin
      count_en_out = osc_free_en;
    end else begin
      unique case (clk_sel_in)
        CLK_INT_OSC: count_en_out = osc_gated_en;
        CLK_XTAL: count_en_out = xtal_en;
        CLK_STOP_A: count_en_out = 1'b0;
        CLK_STOP_B: count_en_out = 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire
